// ==== inc/nde_pkg.sv ====
package nde_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0]  OFS_CMD       = 8'h00;
  localparam logic [7:0]  OFS_CFG       = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_DEST_HIGH = 8'h0c;
  localparam logic [7:0]  OFS_DEST_LOW  = 8'h10;
  localparam int          ADDR_W        = 8;
  // ==========================================================
  // command register fields
  localparam int          CMD_OP_LSB    = 0;
  localparam int          CMD_OP_W      = 2;
  localparam int          CMD_ID_BIT    = 2;
  localparam logic [1:0]  OP_DISCOVER   = 2'h1;
  localparam logic [1:0]  OP_FIND_DEST  = 2'h2;
  // ==========================================================
  // config register fields and reset values
  localparam int          CFG_TMO_LSB   = 0;
  localparam int          TMO_W         = 8;
  localparam int          CFG_COMPAT_LSB = 8;
  localparam int          COMPAT_W      = 2;
  localparam int          COMPAT_LEGACY_BIT = 1;
  localparam int          CFG_API_BIT   = 12;
  localparam logic [7:0]  TMO_RESET     = 8'h0a;
  localparam logic [1:0]  COMPAT_RESET  = 2'h0;
  // ==========================================================
  // status register fields
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_DONE_BIT   = 1;
  localparam int          ST_OK_BIT     = 2;
  localparam int          ST_REFUSED_BIT = 3;
  localparam int          ST_CNT_LSB    = 8;
  localparam int          CNT_W         = 8;
  // ==========================================================
  // host events
  typedef enum logic [2:0] {
    NDE_EVT_NONE      = 3'h0,
    NDE_EVT_REPLY     = 3'h1,
    NDE_EVT_CRLF      = 3'h2,
    NDE_EVT_OK_TEXT   = 3'h3,
    NDE_EVT_ERR_TEXT  = 3'h4,
    NDE_EVT_OK_FRAME  = 3'h5,
    NDE_EVT_ERR_FRAME = 3'h6
  } nde_evt_t;
  localparam logic [7:0]  FRAME_CMD_RESP = 8'h88;
  localparam logic [15:0] SHORT_IS_LONG  = 16'hfffe;
  // ==========================================================
  // timing: one timeout unit in ms, clock period in ns
  localparam int          TMO_UNIT_MS   = 100;
  localparam int          CLK_NS        = 20;
  localparam int          UNIT_CYCLES   = TMO_UNIT_MS * (1000000 / CLK_NS);
endpackage : nde_pkg

// ==== verilog/nde_node_discovery.sv ====
// Overview of operation
// - plain discovery broadcasts a query; every node on the network replies
// - text mode: other commands refused while plain discovery pends until timeout
// - text mode plain discovery timeout emits one extra CRLF, replies or not
// - API mode: each reply a frame, silent if none, no command until timeout
// - legacy bit 1, API, no reply: timeout emits success frame type 0x88
// - directed discovery broadcasts identifier; only matching node answers
// - transparent directed: reply then CRLF ends it; timeout gives ERROR text
// - API directed: reply frame ends at once; timeout gives error frame
// - legacy bit 1: directed waits full timeout, then reports success
// - find-destination broadcasts identifier; first match loads destination, succeeds
// - find-destination success: text prints OK and exits; API ready again
// - find-destination without identifier fails at once, no broadcast
// - find-destination with no match fails when timeout expires
// - find-destination forwards nothing to host, only updates destination
// - short responder: destination_high zero, destination_low the short address
// - responder short FFFE: destination takes responder serial high and low
module nde_node_discovery
  import nde_pkg::*;
#(
  parameter int UNIT_CYC = nde_pkg::UNIT_CYCLES  // cycles per timeout unit
) (
  input  wire logic                     clk,             // 50 MHz clock
  input  wire logic                     resetn,          // async reset, low
  input  wire logic                     psel,            // apb select
  input  wire logic                     penable,         // apb enable
  input  wire logic                     pwrite,          // apb direction
  input  wire logic [nde_pkg::ADDR_W-1:0] paddr,         // apb byte address
  input  wire logic [31:0]              pwdata,          // apb write data
  output logic      [31:0]              prdata,          // apb read data
  output logic                          pready,          // apb ready
  output logic                          pslverr,         // apb error
  input  wire logic                     reply_valid,     // peer reply pulse
  input  wire logic                     reply_match,     // identifier matched
  input  wire logic [15:0]              reply_short,     // peer own_short_address
  input  wire logic [31:0]              reply_serial_high, // peer serial_high
  input  wire logic [31:0]              reply_serial_low,  // peer serial_low
  output logic                          query_valid,     // broadcast pulse
  output logic                          query_directed,  // query carries identifier
  output logic                          cmd_busy,        // command pending
  output logic                          host_evt_valid,  // host event pulse
  output nde_pkg::nde_evt_t             host_evt_code,   // host event kind
  output logic      [7:0]               host_frame_type, // frame type for api
  output logic      [15:0]              host_reply_short, // forwarded reply
  output logic      [31:0]              host_reply_serial_high, // forwarded serial_high
  output logic      [31:0]              host_reply_serial_low,  // forwarded serial_low
  output logic                          exit_cmd_mode    // leave text mode pulse
);
  import nde_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    NDE_IDLE   = 4'b0001,
    NDE_QUERY  = 4'b0010,
    NDE_WAIT   = 4'b0100,
    NDE_FINISH = 4'b1000
  } nde_state_t;

  typedef struct packed {
    nde_state_t           st;
    logic [1:0]           op;
    logic                 directed;
    logic                 matched;
    nde_evt_t             final_evt;
    logic                 final_exit;
    logic [31:0]          unit_cnt;
    logic [TMO_W-1:0]     tmo_cnt;
    logic [CNT_W-1:0]     replies;
    logic [TMO_W-1:0]     discovery_timeout;
    logic [COMPAT_W-1:0]  legacy_compat_bits;
    logic                 api_mode;
    logic                 done;
    logic                 ok;
    logic                 refused;
    logic [31:0]          destination_high;
    logic [31:0]          destination_low;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 query_valid;
    logic                 query_directed;
    logic                 host_evt_valid;
    nde_evt_t             host_evt_code;
    logic [7:0]           host_frame_type;
    logic [15:0]          host_reply_short;
    logic [31:0]          host_reply_serial_high;
    logic [31:0]          host_reply_serial_low;
    logic                 exit_cmd_mode;
    logic                 busy;
  } nde_regs_t;

  nde_regs_t r_q;
  nde_regs_t r_d;

  logic                 legacy;
  logic                 setup;
  logic                 wr_acc;
  logic                 cmd_wr;
  logic [CMD_OP_W-1:0]  wr_op;
  logic                 wr_id;
  logic [31:0]          rd_val;
  logic                 rd_ok;
  logic [31:0]          unit_last;
  logic                 st_idle;
  logic                 find_op;
  logic                 cmd_refuse;
  logic                 reply_take;
  logic                 tmo_over;
  logic                 unit_tick;
  logic                 final_frame;

  // ==========================================================
  // bus and timeout decode
  assign legacy    = r_q.legacy_compat_bits[COMPAT_LEGACY_BIT];
  assign setup     = psel & penable & ~r_q.pready;
  assign wr_acc    = psel & penable & r_q.pready & pwrite & ~r_q.pslverr;
  assign cmd_wr    = wr_acc & (paddr == OFS_CMD);
  assign wr_op     = pwdata[CMD_OP_LSB +: CMD_OP_W];
  assign wr_id     = pwdata[CMD_ID_BIT];
  assign unit_last = UNIT_CYC - 1;
  assign st_idle   = (r_q.st == NDE_IDLE);
  assign find_op   = (r_q.op == OP_FIND_DEST);
  // command write to a busy engine is refused, not queued
  assign cmd_refuse = pwrite & (paddr == OFS_CMD) & ~st_idle;
  // directed: first matching reply only
  assign reply_take = reply_valid & (~r_q.directed | reply_match) & ~r_q.matched;
  assign tmo_over   = (r_q.tmo_cnt == '0);
  assign unit_tick  = (r_q.unit_cnt == unit_last);
  assign final_frame = (r_q.final_evt == NDE_EVT_OK_FRAME) |
                       (r_q.final_evt == NDE_EVT_ERR_FRAME);

  // ==========================================================
  // read mux
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    case (paddr)
      OFS_CMD: begin
        rd_val[CMD_OP_LSB +: CMD_OP_W] = r_q.op;
        rd_val[CMD_ID_BIT]             = r_q.directed;
      end
      OFS_CFG: begin
        rd_val[CFG_TMO_LSB +: TMO_W]       = r_q.discovery_timeout;
        rd_val[CFG_COMPAT_LSB +: COMPAT_W] = r_q.legacy_compat_bits;
        rd_val[CFG_API_BIT]                = r_q.api_mode;
      end
      OFS_STATUS: begin
        rd_val[ST_BUSY_BIT]            = (r_q.st != NDE_IDLE);
        rd_val[ST_DONE_BIT]            = r_q.done;
        rd_val[ST_OK_BIT]              = r_q.ok;
        rd_val[ST_REFUSED_BIT]         = r_q.refused;
        rd_val[ST_CNT_LSB +: CNT_W]    = r_q.replies;
      end
      OFS_DEST_HIGH: rd_val = r_q.destination_high;
      OFS_DEST_LOW:  rd_val = r_q.destination_low;
      default:       rd_ok  = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    r_d                = r_q;
    r_d.query_valid    = 1'b0;
    r_d.host_evt_valid = 1'b0;
    r_d.exit_cmd_mode  = 1'b0;

    // apb: answer one cycle into the access phase
    r_d.pready  = setup;
    if (setup) begin
      r_d.prdata  = pwrite ? 32'h0 : rd_val;
      // status is read only; busy refuses a command
      r_d.pslverr = ~rd_ok | (pwrite & (paddr == OFS_STATUS)) | cmd_refuse;
      if (cmd_refuse) begin
        r_d.refused = 1'b1;
      end
    end else begin
      r_d.pslverr = 1'b0;
    end
    // write lands at the pready edge
    if (wr_acc) begin
      case (paddr)
        OFS_CFG: begin
          r_d.discovery_timeout  = pwdata[CFG_TMO_LSB +: TMO_W];
          r_d.legacy_compat_bits = pwdata[CFG_COMPAT_LSB +: COMPAT_W];
          r_d.api_mode           = pwdata[CFG_API_BIT];
        end
        OFS_DEST_HIGH: r_d.destination_high = pwdata;
        OFS_DEST_LOW:  r_d.destination_low  = pwdata;
        default: begin
        end
      endcase
    end

    // command sequencer
    case (r_q.st)
      NDE_IDLE: begin
        // other op codes start nothing
        if (cmd_wr && (wr_op == OP_DISCOVER || wr_op == OP_FIND_DEST)) begin
          r_d.op       = wr_op;
          r_d.directed = wr_id;
          r_d.matched  = 1'b0;
          r_d.replies  = '0;
          r_d.done     = 1'b0;
          r_d.ok       = 1'b0;
          r_d.refused  = 1'b0;
          if (wr_op == OP_FIND_DEST && !wr_id) begin
            // no identifier: fail at once, nothing sent
            r_d.final_evt = r_q.api_mode ? NDE_EVT_ERR_FRAME : NDE_EVT_ERR_TEXT;
            r_d.st        = NDE_FINISH;
          end else begin
            r_d.st = NDE_QUERY;
          end
        end
      end
      NDE_QUERY: begin
        // timeout starts with the query
        r_d.query_valid    = 1'b1;
        r_d.query_directed = r_q.directed;
        r_d.tmo_cnt        = r_q.discovery_timeout;
        r_d.unit_cnt       = '0;
        r_d.st             = NDE_WAIT;
      end
      NDE_WAIT: begin
        // timeout base
        if (unit_tick) begin
          r_d.unit_cnt = '0;
          if (r_q.tmo_cnt != '0) begin
            r_d.tmo_cnt = r_q.tmo_cnt - 1'b1;
          end
        end else begin
          r_d.unit_cnt = r_q.unit_cnt + 32'h1;
        end
        // expiry beats a same-cycle reply
        if (tmo_over) begin
          r_d.st = NDE_FINISH;
          if (find_op) begin
            r_d.final_evt = r_q.api_mode ? NDE_EVT_ERR_FRAME : NDE_EVT_ERR_TEXT;
          end else if (!r_q.directed) begin
            r_d.ok = 1'b1;
            if (!r_q.api_mode) begin
              r_d.final_evt = NDE_EVT_CRLF;
            end else if (legacy && r_q.replies == '0) begin
              r_d.final_evt = NDE_EVT_OK_FRAME;
            end else begin
              r_d.final_evt = NDE_EVT_NONE;
            end
          end else if (legacy) begin
            r_d.ok        = 1'b1;
            r_d.final_evt = r_q.api_mode ? NDE_EVT_OK_FRAME : NDE_EVT_OK_TEXT;
          end else begin
            r_d.final_evt = r_q.api_mode ? NDE_EVT_ERR_FRAME : NDE_EVT_ERR_TEXT;
          end
        end else if (reply_take) begin
          if (find_op) begin
            // only the destination changes; host sees no reply
            if (reply_short == SHORT_IS_LONG) begin
              r_d.destination_high = reply_serial_high;
              r_d.destination_low  = reply_serial_low;
            end else begin
              r_d.destination_high = '0;
              r_d.destination_low  = {16'h0, reply_short};
            end
            r_d.ok         = 1'b1;
            r_d.final_evt  = r_q.api_mode ? NDE_EVT_OK_FRAME : NDE_EVT_OK_TEXT;
            r_d.final_exit = ~r_q.api_mode;
            r_d.st         = NDE_FINISH;
          end else begin
            r_d.host_evt_valid   = 1'b1;
            r_d.host_evt_code    = NDE_EVT_REPLY;
            r_d.host_frame_type  = '0;
            r_d.host_reply_short = reply_short;
            r_d.host_reply_serial_high = reply_serial_high;
            r_d.host_reply_serial_low  = reply_serial_low;
            // saturate, no wrap
            if (r_q.replies != {CNT_W{1'b1}}) begin
              r_d.replies = r_q.replies + 1'b1;
            end
            if (r_q.directed) begin
              r_d.matched = 1'b1;
              // legacy holds until timeout
              if (!legacy) begin
                r_d.ok        = 1'b1;
                r_d.final_evt = r_q.api_mode ? NDE_EVT_NONE : NDE_EVT_CRLF;
                r_d.st        = NDE_FINISH;
              end
            end
          end
        end
      end
      NDE_FINISH: begin
        // closing host event, back to idle
        if (r_q.final_evt != NDE_EVT_NONE) begin
          r_d.host_evt_valid  = 1'b1;
          r_d.host_evt_code   = r_q.final_evt;
          r_d.host_frame_type = final_frame ? FRAME_CMD_RESP : 8'h0;
        end
        r_d.exit_cmd_mode = r_q.final_exit;
        r_d.final_exit    = 1'b0;
        r_d.final_evt     = NDE_EVT_NONE;
        r_d.done          = 1'b1;
        r_d.st            = NDE_IDLE;
      end
      default: begin
        r_d.st = NDE_IDLE;
      end
    endcase
    // busy has its own flip-flop
    r_d.busy = (r_d.st != NDE_IDLE);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_q                    <= '0;
      r_q.st                 <= NDE_IDLE;
      r_q.final_evt          <= NDE_EVT_NONE;
      r_q.host_evt_code      <= NDE_EVT_NONE;
      r_q.discovery_timeout  <= TMO_RESET;
      r_q.legacy_compat_bits <= COMPAT_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata           = r_q.prdata;
  assign pready           = r_q.pready;
  assign pslverr          = r_q.pslverr;
  assign query_valid      = r_q.query_valid;
  assign query_directed   = r_q.query_directed;
  assign cmd_busy         = r_q.busy;
  assign host_evt_valid   = r_q.host_evt_valid;
  assign host_evt_code    = r_q.host_evt_code;
  assign host_frame_type  = r_q.host_frame_type;
  assign host_reply_short = r_q.host_reply_short;
  assign host_reply_serial_high = r_q.host_reply_serial_high;
  assign host_reply_serial_low  = r_q.host_reply_serial_low;
  assign exit_cmd_mode    = r_q.exit_cmd_mode;
endmodule : nde_node_discovery

// ==== tb/nde_node_discovery_props.sv ====
module nde_node_discovery_props
  import nde_pkg::*;
#(
  parameter int UNIT_CYC = nde_pkg::UNIT_CYCLES  // cycles per unit
) (
  input wire logic                 clk,              // clock
  input wire logic                 resetn,           // reset, low
  input wire logic                 psel,             // apb select
  input wire logic                 penable,          // apb enable
  input wire logic                 pwrite,           // apb direction
  input wire logic [ADDR_W-1:0]    paddr,            // apb address
  input wire logic [31:0]          pwdata,           // apb write data
  input wire logic                 pready,           // apb ready
  input wire logic                 pslverr,          // apb error
  input wire logic                 reply_valid,      // peer reply
  input wire logic [15:0]          reply_short,      // peer address
  input wire logic                 query_valid,      // broadcast
  input wire logic                 query_directed,   // with identifier
  input wire logic                 cmd_busy,         // pending
  input wire logic                 host_evt_valid,   // event
  input wire nde_pkg::nde_evt_t    host_evt_code,    // event kind
  input wire logic [7:0]           host_frame_type,  // frame type
  input wire logic [15:0]          host_reply_short, // forwarded
  input wire logic                 exit_cmd_mode     // leave text mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // helper state: last command, timeout, busy span
  logic [2:0] cmd_q;
  int         tmo_q;
  int         bc;
  wire        acc = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= 3'h0;
      tmo_q <= int'(TMO_RESET);
      bc    <= 0;
    end else begin
      if (acc && paddr == OFS_CMD) cmd_q <= pwdata[2:0];
      if (acc && paddr == OFS_CFG) tmo_q <= int'(pwdata[7:0]);
      bc <= cmd_busy ? bc + 1 : 0;
    end
  end
  // ==========================================
  // properties
  a_query_after_cmd:
  assert property (acc && paddr == OFS_CMD && pwdata[1:0] == OP_DISCOVER |-> ##2
    query_valid && query_directed == $past(pwdata[2], 2)) else $error("query missing");
  a_query_one_pulse:
  assert property (query_valid |=> !query_valid) else $error("query longer than a cycle");
  a_refuse_busy:
  assert property (psel && penable && pready && pwrite && paddr == OFS_CMD && cmd_busy
    && $past(cmd_busy) |-> pslverr) else $error("command taken while busy");
  a_reply_fwd:
  assert property (reply_valid && cmd_busy && cmd_q == 3'h1 && !query_valid |=> host_evt_valid
    && host_evt_code == NDE_EVT_REPLY && host_reply_short == $past(reply_short))
    else $error("reply not forwarded");
  a_frame_type:
  assert property (host_evt_valid && host_evt_code inside {NDE_EVT_OK_FRAME, NDE_EVT_ERR_FRAME}
    |-> host_frame_type == FRAME_CMD_RESP) else $error("bad frame type");
  a_exit_with_ok:
  assert property (exit_cmd_mode |-> host_evt_valid && host_evt_code == NDE_EVT_OK_TEXT)
    else $error("exit without ok");
  a_find_silent:
  assert property (cmd_busy && cmd_q[1:0] == OP_FIND_DEST |-> !(host_evt_valid
    && host_evt_code == NDE_EVT_REPLY)) else $error("find forwarded a reply");
  a_noid_no_query:
  assert property (acc && paddr == OFS_CMD && pwdata[2:0] == {1'b0, OP_FIND_DEST}
    |=> !query_valid [*3]) else $error("query without identifier");
  a_tmo_bound:
  assert property (cmd_busy |-> bc <= tmo_q * UNIT_CYC + 6) else $error("timeout overrun");
endmodule : nde_node_discovery_props

bind nde_node_discovery nde_node_discovery_props #(.UNIT_CYC(UNIT_CYC)) u_props (
  .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .reply_valid, .reply_short, .query_valid, .query_directed, .cmd_busy,
  .host_evt_valid, .host_evt_code, .host_frame_type, .host_reply_short, .exit_cmd_mode);

// ==== tb/nde_peer_model.sv ====
module nde_peer_model (
  input  wire logic        clk,               // clock
  input  wire logic        resetn,            // reset, low
  input  wire logic        query_valid,       // broadcast seen
  input  wire logic [7:0]  n_rsp,             // replies per query
  input  wire logic [7:0]  dly,               // gap in cycles
  input  wire logic        rsp_match,         // identifier matched
  input  wire logic [15:0] rsp_short,         // own_short_address
  input  wire logic [31:0] rsp_serial_high,   // serial_high
  input  wire logic [31:0] rsp_serial_low,    // serial_low
  output logic             reply_valid,       // reply pulse
  output logic             reply_match,       // match flag
  output logic [15:0]      reply_short,       // address
  output logic [31:0]      reply_serial_high, // serial high
  output logic [31:0]      reply_serial_low   // serial low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left;
  logic [7:0] t;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left <= 8'h00;
      t <= 8'h00;
      reply_valid <= 1'b0;
    end else begin
      // released lines toggle so stale data never looks valid
      reply_valid <= 1'b0;
      reply_match <= ~reply_match;
      reply_short <= ~reply_short;
      reply_serial_high <= ~reply_serial_high;
      reply_serial_low <= ~reply_serial_low;
      if (query_valid) begin
        left <= n_rsp;
        t <= dly;
      end else if (left != 8'h00) begin
        if (t == 8'h00) begin
          reply_valid <= 1'b1;
          reply_match <= rsp_match;
          reply_short <= rsp_short;
          reply_serial_high <= rsp_serial_high;
          reply_serial_low <= rsp_serial_low;
          left <= left - 8'h01;
          t <= dly;
        end else t <= t - 8'h01;
      end
    end
  end
endmodule : nde_peer_model

// ==== tb/test_node_discovery_engine.sv ====
module test_node_discovery_engine
  import nde_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, pn = 8'h00, pd = 8'h01, host_frame_type;
  logic [31:0] pwdata = 32'h0, psh = 32'h0, psl = 32'h0, prdata, reply_serial_high;
  logic [31:0] reply_serial_low, host_reply_serial_high, host_reply_serial_low, got[$];
  logic [15:0] ps = 16'h0, reply_short, host_reply_short;
  logic pm = 1'b0, pready, pslverr, reply_valid, reply_match, query_valid, query_directed;
  logic cmd_busy, host_evt_valid, exit_cmd_mode, qexp;
  nde_evt_t host_evt_code;
  int want[$], nq, nx, miscompares = 0, tests_run = 0;
  nde_node_discovery #(.UNIT_CYC(4)) uut (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .reply_valid, .reply_match, .reply_short,
    .reply_serial_high, .reply_serial_low, .query_valid, .query_directed, .cmd_busy,
    .host_evt_valid, .host_evt_code, .host_frame_type, .host_reply_short,
    .host_reply_serial_high, .host_reply_serial_low, .exit_cmd_mode);
  nde_peer_model u_peer (.clk, .resetn, .query_valid, .n_rsp(pn), .dly(pd), .rsp_match(pm),
    .rsp_short(ps), .rsp_serial_high(psh), .rsp_serial_low(psl), .reply_valid, .reply_match,
    .reply_short, .reply_serial_high, .reply_serial_low);
  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================
  // checking
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  always @(posedge clk) begin
    if (host_evt_valid === 1'b1) begin
      got.push_back({29'h0, host_evt_code});
      cmp("frame_type", host_evt_code inside {NDE_EVT_OK_FRAME, NDE_EVT_ERR_FRAME} ?
          32'h88 : 32'h0, {24'h0, host_frame_type});
      if (host_evt_code === NDE_EVT_REPLY) begin
        cmp("fwd_short", ps, host_reply_short);
        cmp("fwd_high", psh, host_reply_serial_high);
        cmp("fwd_low", psl, host_reply_serial_low);
      end
    end
    if (query_valid === 1'b1) begin
      nq++;
      cmp("directed", qexp, query_directed);
    end
    if (exit_cmd_mode === 1'b1) nx++;
  end
  // ==========================================
  // reference model of host events
  function automatic void model(bit api, leg, dir, fd, id, int n, bit m);
    bit hit;
    hit = n > 0 && m;
    want.delete();
    if (fd) want.push_back(id && hit ? (api ? 5 : 3) : (api ? 6 : 4));
    else if (!dir) begin
      repeat (n) want.push_back(1);
      if (!api) want.push_back(2);
      else if (leg && n == 0) want.push_back(5);
    end else if (leg) begin
      if (hit) want.push_back(1);
      want.push_back(api ? 5 : 3);
    end else if (hit) begin
      want.push_back(1);
      if (!api) want.push_back(2);
    end else want.push_back(api ? 6 : 4);
  endfunction : model
  // ==========================================
  // bus and scenarios
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) cmp("pready", 1, 0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input bit api, leg, dir, fd, id, lg, input int n, input bit m);
    logic [31:0] d;
    logic e;
    int k, nr;
    pn <= 8'(n);
    pd <= 8'($urandom_range(1, 2));
    pm <= m;
    ps <= lg ? 16'hfffe : 16'($urandom_range(0, 65533));
    psh <= $urandom;
    psl <= $urandom;
    model(api, leg, dir, fd, id, n, m);
    got.delete();
    nq = 0;
    nx = 0;
    qexp = dir | fd & id;
    apb(1'b1, OFS_CFG, {19'h0, api, 2'h0, leg, 1'b0, 8'h03}, d, e);
    apb(1'b1, OFS_CMD, {29'h0, dir | id, fd ? OP_FIND_DEST : OP_DISCOVER}, d, e);
    cmp("cmd_err", 0, e);
    if (!dir && !fd) begin
      apb(1'b1, OFS_CMD, 32'h1, d, e);
      cmp("busy_err", 1, e);
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((cmd_busy === 1'b1 || k < 4) && k < 300);
    if (k >= 300) cmp("busy_end", 0, 1);
    repeat (3) @(posedge clk);
    cmp("evt_count", want.size(), got.size());
    foreach (want[i]) cmp("evt_code", want[i], got[i]);
    cmp("queries", (fd && !id) ? 0 : 1, nq);
    cmp("exits", fd && id && n > 0 && m && !api, nx);
    nr = 0;
    foreach (want[i]) nr += (want[i] == 1);
    apb(1'b0, OFS_STATUS, 32'h0, d, e);
    cmp("status", {16'h0, 8'(nr), 4'h0, !dir && !fd,
                   fd ? id && n > 0 && m : !dir || leg || n > 0 && m, 2'b10}, d);
    if (fd && id && n > 0 && m) begin
      apb(1'b0, OFS_DEST_HIGH, 32'h0, d, e);
      cmp("dest_high", lg ? psh : 32'h0, d);
      apb(1'b0, OFS_DEST_LOW, 32'h0, d, e);
      cmp("dest_low", lg ? psl : {16'h0, ps}, d);
    end
  endtask : run
  initial begin
    logic [31:0] rd;
    logic er;
    void'($urandom(32'h0f26));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, OFS_CFG, 32'h0, rd, er);
    cmp("cfg_reset", 32'h0a, rd);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    cmp("unmapped", 1, er);
    apb(1'b1, OFS_STATUS, 32'h0, rd, er);
    cmp("status_ro", 1, er);
    run(0, 0, 0, 0, 0, 0, 2, 1);
    run(0, 0, 0, 0, 0, 0, 0, 1);
    run(1, 0, 0, 0, 0, 0, 3, 1);
    run(1, 0, 0, 0, 0, 0, 0, 1);
    run(1, 1, 0, 0, 0, 0, 0, 1);
    run(0, 0, 1, 0, 1, 0, 1, 1);
    run(0, 0, 1, 0, 1, 0, 2, 0);
    run(1, 0, 1, 0, 1, 0, 1, 1);
    run(1, 0, 1, 0, 1, 0, 0, 1);
    run(1, 1, 1, 0, 1, 0, 2, 1);
    run(1, 1, 1, 0, 1, 0, 0, 1);
    run(0, 0, 0, 1, 1, 0, 1, 1);
    run(1, 0, 0, 1, 1, 1, 1, 1);
    run(0, 0, 0, 1, 0, 0, 1, 1);
    run(1, 0, 0, 1, 1, 0, 2, 0);
    results;
  end
  initial begin
    #100000;
    miscompares++;
    results;
  end
endmodule : test_node_discovery_engine
